// [aacq_pkg.sv]
// Constants for the acquisition register port: offsets, fields, timing.
// Assumes a 20 MHz system clock shared with the local register bus.
package aacq_pkg;
  // Bank one register offsets (byte offsets in the I/O window)
  localparam logic [3:0] OFF_DATA_CHAN = 4'h0;
  localparam logic [3:0] OFF_GAIN_STAT = 4'h2;
  localparam logic [3:0] OFF_TRIG_MODE = 4'h4;
  localparam logic [3:0] OFF_IRQ_CTRL = 4'h6;
  localparam logic [3:0] OFF_SOFT_TRIG = 4'h8;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'ha;
  // Field positions
  localparam int TM_AUTO_SCAN = 0;
  localparam int TM_TRIG_SRC = 1;
  localparam int IC_FIRST_SRC = 0;
  localparam int IC_SECOND_SRC = 1;
  localparam int IC_QUEUE_DIS = 2;
  localparam int WORD_CHAN_LSB = 16;
  // Reset values
  localparam logic [4:0] CHAN_RESET = 5'h00;
  localparam logic [1:0] GAIN_RESET = 2'h0;
  localparam logic [2:0] IRQ_CTRL_RESET = 3'h0;
  // Conversion time limit
  localparam int CLK_HZ = 20_000_000;
  localparam int CONV_MAX_NS = 8500;
  localparam int CONV_MAX_CYC = (CONV_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int CONV_CYC = 100;
endpackage

// [aacq_port.sv]
// Acquisition register port: bank one 16-bit registers, bank two 32-bit
// word, sample queue, auto-scan, triggers and the level interrupt.
// Assumes the PCI bridge presents decoded I/O strobes on this clock and
// that the converter returns a sample with a done pulse.
`timescale 1ns/1ns

module aacq_port #(
  parameter int DEPTH = 1024,
  parameter int AW = 10
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  input wire logic I_BANK1_SEL,
  input wire logic I_BANK2_SEL,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [3:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  output logic [31:0] O_RDATA,
  input wire logic I_PACER,
  input wire logic I_TIMER_IRQ,
  input wire logic [11:0] I_SAMPLE,
  input wire logic I_SAMPLE_DONE,
  output logic O_CONVERT,
  output logic [4:0] O_CHANNEL,
  output logic [1:0] O_GAIN,
  output logic O_IRQ
);
  logic [4:0] chan_last_q;
  logic [4:0] scan_chan_q;
  logic [1:0] gain_q;
  logic auto_scan_q;
  logic trig_src_q;
  logic [2:0] irq_ctrl_q;
  logic busy_q;
  logic [15:0] conv_cnt_q;
  logic [16:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic irq_q;
  logic [2:0] pace_sync_q;
  logic [2:0] tmr_sync_q;
  logic pace_lvl_q;
  logic tmr_lvl_q;
  logic pace_rise;
  logic tmr_rise;
  logic wr1;
  logic rd_pop;
  logic soft_trig;
  logic trig;
  logic push;
  logic pop;
  logic q_empty;
  logic q_full;
  logic q_half;

  // Bus target decode; bridge handles addressing from config bases
  assign wr1 = I_BANK1_SEL & I_WR;
  assign rd_pop = (I_BANK1_SEL & I_RD & (I_ADDR == aacq_pkg::OFF_DATA_CHAN))
    | (I_BANK2_SEL & I_RD);
  assign soft_trig = wr1 & (I_ADDR == aacq_pkg::OFF_SOFT_TRIG);
  assign q_empty = (count_q == '0);
  assign q_full = (count_q == (AW+1)'(DEPTH));
  assign q_half = (count_q >= (AW+1)'(DEPTH / 2));

  // Pacer and timer pins pass three flops; edge needs 2nd and 3rd agreeing
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      pace_sync_q <= 3'h0;
      tmr_sync_q <= 3'h0;
      pace_lvl_q <= 1'b0;
      tmr_lvl_q <= 1'b0;
    end
    else
    begin
      pace_sync_q <= {pace_sync_q[1:0], I_PACER};
      tmr_sync_q <= {tmr_sync_q[1:0], I_TIMER_IRQ};
      if (pace_sync_q[1] == pace_sync_q[2])
        pace_lvl_q <= pace_sync_q[2];
      if (tmr_sync_q[1] == tmr_sync_q[2])
        tmr_lvl_q <= tmr_sync_q[2];
    end
  end
  assign pace_rise = (pace_sync_q[1] == pace_sync_q[2]) & pace_sync_q[2]
    & ~pace_lvl_q;
  assign tmr_rise = (tmr_sync_q[1] == tmr_sync_q[2]) & tmr_sync_q[2]
    & ~tmr_lvl_q;

  // Trigger source choice; a trigger while busy is ignored
  assign trig = (trig_src_q ? pace_rise : soft_trig) & ~busy_q;
  assign O_CONVERT = trig;

  // Control registers; unused bits are simply not stored
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      chan_last_q <= aacq_pkg::CHAN_RESET;
      gain_q <= aacq_pkg::GAIN_RESET;
      auto_scan_q <= 1'b0;
      trig_src_q <= 1'b0;
      irq_ctrl_q <= aacq_pkg::IRQ_CTRL_RESET;
    end
    else if (wr1)
    begin
      unique case (I_ADDR)
        aacq_pkg::OFF_DATA_CHAN: chan_last_q <= I_WDATA[4:0];
        aacq_pkg::OFF_GAIN_STAT: gain_q <= I_WDATA[1:0];
        aacq_pkg::OFF_TRIG_MODE:
        begin
          auto_scan_q <= I_WDATA[aacq_pkg::TM_AUTO_SCAN];
          trig_src_q <= I_WDATA[aacq_pkg::TM_TRIG_SRC];
        end
        aacq_pkg::OFF_IRQ_CTRL: irq_ctrl_q <= I_WDATA[2:0];
        default: ;
      endcase
    end
  end

  // Scan counter: steps on each trigger, wraps after the last channel
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
      scan_chan_q <= 5'h00;
    else if (!auto_scan_q)
      scan_chan_q <= 5'h00;
    else if (trig)
      scan_chan_q <= (scan_chan_q >= chan_last_q) ? 5'h00
        : scan_chan_q + 5'h01;
  end

  // Channel shown to the mux; held for the sample tag during conversion
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      O_CHANNEL <= 5'h00;
      O_GAIN <= 2'h0;
    end
    else
    begin
      if (trig)
        O_CHANNEL <= auto_scan_q ? scan_chan_q : chan_last_q;
      O_GAIN <= gain_q;
    end
  end

  // Busy spans trigger to store; internal timeout bounds the wait
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
    begin
      busy_q <= 1'b0;
      conv_cnt_q <= 16'h0000;
    end
    else if (trig)
    begin
      busy_q <= 1'b1;
      conv_cnt_q <= 16'h0000;
    end
    else if (busy_q)
    begin
      conv_cnt_q <= conv_cnt_q + 16'h0001;
      if (push || conv_cnt_q == 16'(aacq_pkg::CONV_CYC))
        busy_q <= 1'b0;
    end
  end

  // Store on converter done, or on the timeout so 8.5 us is never missed
  assign push = busy_q & (I_SAMPLE_DONE
    | (conv_cnt_q == 16'(aacq_pkg::CONV_CYC)));
  assign pop = rd_pop & ~q_empty;

  // Sample queue; disable bit flushes and blocks new samples
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET || irq_ctrl_q[aacq_pkg::IC_QUEUE_DIS])
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push && !q_full)
      begin
        mem[wr_ptr_q] <= {O_CHANNEL, I_SAMPLE};
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop)
        rd_ptr_q <= rd_ptr_q + AW'(1);
      count_q <= count_q + (AW+1)'(push && !q_full) - (AW+1)'(pop);
    end
  end

  // Read mux; registered data, unused bits zero
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
      O_RDATA <= 32'h0000_0000;
    else if (I_BANK2_SEL && I_RD)
      O_RDATA <= {11'h000, mem[rd_ptr_q][16:12], 4'h0,
        mem[rd_ptr_q][11:0]};
    else if (I_BANK1_SEL && I_RD)
    begin
      unique case (I_ADDR)
        aacq_pkg::OFF_DATA_CHAN:
          O_RDATA <= {20'h00000, mem[rd_ptr_q][11:0]};
        aacq_pkg::OFF_GAIN_STAT:
          O_RDATA <= {28'h0000000, ~busy_q, ~q_full, ~q_half,
            ~q_empty};
        aacq_pkg::OFF_TRIG_MODE:
          O_RDATA <= {28'h0000000, gain_q, trig_src_q, auto_scan_q};
        aacq_pkg::OFF_IRQ_CTRL:
          O_RDATA <= {29'h00000000, irq_ctrl_q};
        default: O_RDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Level interrupt: set wins over a same-cycle clear
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RESET)
      irq_q <= 1'b0;
    else if ((irq_ctrl_q[aacq_pkg::IC_FIRST_SRC] ? (push && count_q ==
        (AW+1)'(DEPTH / 2 - 1)) : push)
        || (irq_ctrl_q[aacq_pkg::IC_SECOND_SRC] && tmr_rise))
      irq_q <= 1'b1;
    else if (wr1 && I_ADDR == aacq_pkg::OFF_IRQ_CLEAR)
      irq_q <= 1'b0;
  end
  assign O_IRQ = irq_q;

  // Checks; named sequences mark the trigger and store steps
  sequence s_trig;
    trig;
  endsequence
  sequence s_push;
    push;
  endsequence
  chk_busy_on_trig: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) s_trig |=> busy_q) else $error("busy not set");
  chk_conv_bound: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) s_trig |-> ##[1:170] !busy_q)
    else $error("slow conv");
  chk_pop_one: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET || irq_ctrl_q[2]) pop && !push |=> count_q ==
    $past(count_q) - 1) else $error("pop count");
  chk_full_drop: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET || irq_ctrl_q[2]) q_full && !pop
    |=> count_q == $past(count_q)) else $error("full overwrite");
  chk_irq_hold: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) irq_q && !(wr1 && I_ADDR ==
    aacq_pkg::OFF_IRQ_CLEAR) |=> irq_q) else $error("irq dropped");
  chk_irq_clear: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) wr1 && I_ADDR == aacq_pkg::OFF_IRQ_CLEAR && !push
    && !tmr_rise |=> !irq_q) else $error("irq not cleared");
  chk_scan_wrap: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) auto_scan_q && trig && scan_chan_q >= chan_last_q
    |=> scan_chan_q == 5'h00) else $error("no wrap");
  chk_queue_flush: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) irq_ctrl_q[2] |=> count_q == '0)
    else $error("no flush");
  chk_store_idle: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) s_push |=> !busy_q) else $error("busy after store");
  chk_trig_single: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) s_trig |=> !trig) else $error("double trigger");
  chk_gain_follow: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) O_GAIN == $past(gain_q)) else $error("gain lag");
  chk_status_zero: assert property (@(posedge I_SYS_CLK)
    disable iff (I_RESET) I_BANK1_SEL && I_RD && I_ADDR ==
    aacq_pkg::OFF_GAIN_STAT |=> O_RDATA[31:4] == 28'h0000000)
    else $error("status upper bits");
endmodule

// [aacq_conv_model.sv]
// Converter model for the acquisition port: answers each start pulse
// with a done pulse and a sample that encodes the selected channel.
// Assumes it shares the system clock with the port.
`timescale 1ns/1ns
module aacq_conv_model #(
  parameter int DLY = 20
) (
  input wire logic i_clk,
  input wire logic i_convert,
  input wire logic [4:0] i_channel,
  output logic [11:0] o_sample,
  output logic o_done
);
  int cnt_q = 0;
  // Sample bus churns outside done so a stale value never looks valid
  always @(posedge i_clk)
  begin
    o_done <= 1'b0;
    o_sample <= ~o_sample;
    if (i_convert === 1'b1)
      cnt_q <= DLY;
    else if (cnt_q > 1)
      cnt_q <= cnt_q - 1;
    else if (cnt_q == 1)
    begin
      cnt_q <= 0;
      o_done <= 1'b1;
      o_sample <= {7'h2d, i_channel};
    end
  end
  initial o_sample = 12'h000;
endmodule

// [tb.sv]
// Self-checking bench for the acquisition register port.
// Assumes the converter model above and 16-bit host register cycles.
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  logic clk, rst, b1, b2, wr, rd, pacer, tirq, done, conv, irq;
  logic [3:0] addr;
  logic [15:0] wd;
  logic [31:0] rdata, r;
  logic [11:0] smp;
  logic [4:0] ch;
  logic [1:0] gain;
  int miscompares = 0;
  int n_checks = 0;
  int nconv = 0;
  aacq_port dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_BANK1_SEL(b1),
    .I_BANK2_SEL(b2), .I_WR(wr), .I_RD(rd), .I_ADDR(addr), .I_WDATA(wd),
    .O_RDATA(rdata), .I_PACER(pacer), .I_TIMER_IRQ(tirq), .I_SAMPLE(smp),
    .I_SAMPLE_DONE(done), .O_CONVERT(conv), .O_CHANNEL(ch), .O_GAIN(gain),
    .O_IRQ(irq));
  aacq_conv_model model (.i_clk(clk), .i_convert(conv), .i_channel(ch),
    .o_sample(smp), .o_done(done));
  // Clock and a count of start pulses
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (conv === 1'b1) nconv++;
  // One host cycle; strobes held for a single sampling edge
  task automatic acc(input logic w, input logic bk2, input logic [3:0] a,
    input logic [15:0] d);
    @(posedge clk);
    #1 {b1, b2, wr, rd, addr, wd} = {!bk2, bk2, w, !w, a, d};
    @(posedge clk);
    #1 {b1, b2, wr, rd, addr, wd} = {4'h0, ~a, ~d};
    r = rdata;
  endtask
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task automatic cwait();
    repeat (aacq_pkg::CONV_MAX_CYC) @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Gain codes, read-backs, ignored bits, unmapped offset
  task automatic t_regs();
    acc(1'b0, 1'b0, 4'h2, 16'h0);
    `CHK(r, 32'h0000000e)
    for (int g = 0; g < 3; g++)
    begin
      wr16(4'h2, {14'h3fff, g[1:0]});
      @(posedge clk);
      #1 `CHK(gain, g[1:0])
      acc(1'b0, 1'b0, 4'h4, 16'h0);
      `CHK(r, {28'h0, g[1:0], 2'h0})
    end
    wr16(4'h4, 16'hfff3);
    acc(1'b0, 1'b0, 4'h4, 16'h0);
    `CHK(r, 32'h0000000b)
    wr16(4'h6, 16'hfffb);
    acc(1'b0, 1'b0, 4'h6, 16'h0);
    `CHK(r, 32'h00000003)
    wr16(4'h4, 16'h0);
    wr16(4'h6, 16'h0);
    acc(1'b0, 1'b0, 4'hc, 16'h0);
    `CHK(r, 32'h0)
  endtask
  // Single soft conversion, busy flag, read path, interrupt and clear
  task automatic t_single(input logic [4:0] c, input logic bk2);
    int n0;
    n0 = nconv;
    wr16(4'h0, {11'h7ff, c});
    wr16(4'h8, 16'h1234);
    acc(1'b0, 1'b0, 4'h2, 16'h0);
    `CHK(r[3], 1'b0)
    `CHK(nconv, n0 + 1)
    cwait();
    `CHK(ch, c)
    `CHK(irq, 1'b1)
    acc(1'b0, 1'b0, 4'h2, 16'h0);
    `CHK(r, 32'h0000000f)
    acc(1'b0, bk2, 4'h0, 16'h0);
    if (bk2)
      `CHK(r, {11'h0, c, 4'h0, 7'h2d, c})
    else
      `CHK(r, {20'h0, 7'h2d, c})
    acc(1'b0, 1'b0, 4'h2, 16'h0);
    `CHK(r, 32'h0000000e)
    `CHK(irq, 1'b1)
    wr16(4'ha, 16'h5a5a);
    `CHK(irq, 1'b0)
  endtask
  // Scan through channels 0..2 and wrap
  task automatic t_scan();
    wr16(4'h0, 16'h0002);
    wr16(4'h4, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      wr16(4'h8, 16'h0);
      cwait();
      acc(1'b0, 1'b1, 4'h0, 16'h0);
      `CHK(r[20:16], 5'(i % 3))
    end
    wr16(4'h4, 16'h0);
    wr16(4'ha, 16'h0);
  endtask
  // Pacer pin as trigger, then the timer interrupt source
  task automatic t_pins();
    int n0;
    n0 = nconv;
    wr16(4'h4, 16'h0002);
    repeat (2)
    begin
      #200 pacer = 1'b1;
      #200 pacer = 1'b0;
      cwait();
    end
    `CHK(nconv, n0 + 2)
    repeat (2)
    begin
      acc(1'b0, 1'b1, 4'h0, 16'h0);
      `CHK(r[20:16], 5'h02)
    end
    wr16(4'h4, 16'h0);
    wr16(4'ha, 16'h0);
    wr16(4'h6, 16'h0002);
    #200 tirq = 1'b1;
    #200 tirq = 1'b0;
    repeat (10) @(posedge clk);
    `CHK(irq, 1'b1)
    wr16(4'ha, 16'h0);
    `CHK(irq, 1'b0)
    wr16(4'h6, 16'h0);
  endtask
  // Disabled queue drops samples; 0-1-0 toggle empties it
  task automatic t_flush();
    wr16(4'h6, 16'h0004);
    wr16(4'h8, 16'h0);
    cwait();
    wr16(4'h6, 16'h0);
    acc(1'b0, 1'b0, 4'h2, 16'h0);
    `CHK(r, 32'h0000000e)
    wr16(4'h8, 16'h0);
    cwait();
    wr16(4'h6, 16'h0004);
    wr16(4'h6, 16'h0);
    acc(1'b0, 1'b0, 4'h2, 16'h0);
    `CHK(r, 32'h0000000e)
    wr16(4'ha, 16'h0);
  endtask
  // Main sequence
  initial
  begin
    {rst, b1, b2, wr, rd, pacer, tirq, addr, wd} = {7'h40, 4'h0, 16'h0};
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    `CHK({ch, gain, irq, conv}, 9'h000)
    t_regs();
    t_single(5'h1f, 1'b1);
    t_single(5'h07, 1'b0);
    t_scan();
    t_pins();
    t_flush();
    report_and_stop();
  end
endmodule
